/* File: ifs_params.svh */
`ifndef IFS_PARAMS_SVH
`define IFS_PARAMS_SVH
// Default four-bit prefix of the slave address.
`define IFS_PREFIX_DEF 4'ha
// Device-select code that asks for a full erase.
`define IFS_SEL_FULL 3'h7
// Field positions inside the received slave address byte.
`define IFS_DIR_BIT 0
`define IFS_SEL_LSB 1
`define IFS_PFX_LSB 4
// Receive bit count that marks a whole byte.
`define IFS_BYTE_BITS 4'h8
// Default array address width, page size and FIFO depth.
`define IFS_ADDR_W_DEF 8
`define IFS_PAGE_DEF 16
`define IFS_FIFO_DEPTH_DEF 4
// Default erase trigger address of sector 0.
`define IFS_TRIG0_DEF 10'h000
`endif

/* File: ifs_pkg.sv */
`default_nettype none
package ifs_pkg;
  // Erase method fixed when the block is built.
  typedef enum logic [1:0] {
    ER_FULL = 2'h0,
    ER_BYTE = 2'h1,
    ER_SEL  = 2'h2,
    ER_NONE = 2'h3
  } ifs_erase_t;
  // Link-facing bit engine states.
  typedef enum logic [4:0] {
    LS_IDLE = 5'h01,
    LS_RX   = 5'h02,
    LS_ACK  = 5'h04,
    LS_TX   = 5'h08,
    LS_RACK = 5'h10
  } ifs_link_t;
  // Operation picked up from the slave address.
  typedef enum logic [4:0] {
    OP_NONE  = 5'h01,
    OP_WRITE = 5'h02,
    OP_READ  = 5'h04,
    OP_FULL  = 5'h08,
    OP_SECT  = 5'h10
  } ifs_op_t;
  // Commit engine states towards the flash array.
  typedef enum logic [4:0] {
    CS_IDLE  = 5'h01,
    CS_ERASE = 5'h02,
    CS_FILL  = 5'h04,
    CS_GAP   = 5'h08,
    CS_WAIT  = 5'h10
  } ifs_commit_t;
  // One programming word queued for the flash array.
  typedef struct packed {
    logic [9:0] addr;
    logic [7:0] data;
  } ifs_word_t;
endpackage : ifs_pkg
`default_nettype wire

/* File: ifs_top.sv */
`include "ifs_params.svh"
`default_nettype none

// ****************************************************************
// Write queue between the page buffer and the flash array.
// ****************************************************************
module ifs_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = `IFS_FIFO_DEPTH_DEF
) (
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             rst,
  // Filling side.
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side.
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // Refuse shapes the pointers cannot serve.
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("FIFO depth must be a power of two of at least two.");
  end

  logic [WIDTH-1:0] mem_r [DEPTH];  // Storage words.
  logic [PW-1:0]    wptr_r;         // Next slot to fill.
  logic [PW-1:0]    rptr_r;         // Next slot to drain.
  logic [PW:0]      fill_r;         // Words held.
  logic             push;
  logic             pop;

  assign in_ready  = (fill_r != (PW+1)'(DEPTH));
  assign out_valid = (fill_r != '0);
  assign out_data  = mem_r[rptr_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Storage is written only on an accepted word.
  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wptr_r] <= in_data;
    end
  end

  // Pointers and fill level move with each handshake.
  always_ff @(posedge clk) begin
    if (rst) begin
      wptr_r <= '0;
      rptr_r <= '0;
      fill_r <= '0;
    end else begin
      if (push) begin
        wptr_r <= wptr_r + 1'b1;
      end
      if (pop) begin
        rptr_r <= rptr_r + 1'b1;
      end
      fill_r <= fill_r + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule : ifs_fifo

// ****************************************************************
// Two-wire slave that fronts the user flash array.
// ****************************************************************
// Overview of operation
// - Match prefix and three device-select inputs.
// - Address byte LSB one reads, zero writes.
// - Large arrays borrow select bits as address.
// - Acknowledge own address, then do the operation.
// - Byte write: address, byte address, data, stop.
// - Program the flash only after stop.
// - Ignore new transfers while flash is busy.
// - Page write takes 8, 16 or 32 bytes.
// - Withhold address acknowledge until cycle ends.
// - Protect input guards upper half or all.
// - Protected write: not-acknowledge first data byte.
// - Sector or full erase only; none read-only.
// - One erase method chosen at build time.
// - Select code 111 asks for full erase.
// - Full erase starts after stop, then polling.
// - Protected full erase address is not acknowledged.
// - Trigger address erases sector, then writes byte.
// - Trigger defaults: zero and half array size.
// - Third select bit one chooses sector erase.
// - Sector erase named by byte address, after stop.
// - Protected sector byte address is not acknowledged.
// - Data edges with clock high mark start, stop.
// - Acknowledge holds data low during clock high.
// - Protect input is active high.
module ifs_top #(
  parameter int                  ADDR_W     = `IFS_ADDR_W_DEF,
  parameter int                  PAGE       = `IFS_PAGE_DEF,
  parameter int                  FIFO_DEPTH = `IFS_FIFO_DEPTH_DEF,
  parameter logic [3:0]          PREFIX     = `IFS_PREFIX_DEF,
  parameter ifs_pkg::ifs_erase_t ERASE      = ifs_pkg::ER_BYTE,
  parameter bit                  READ_ONLY  = 1'b0,
  parameter bit                  PROT_FULL  = 1'b0,
  parameter logic [9:0]          TRIG0      = `IFS_TRIG0_DEF,
  parameter logic [9:0]          TRIG1      = 10'(1 << (ADDR_W - 1))
) (
  // Clock and reset.
  input  wire logic              CLOCK,
  input  wire logic              RST,
  // Two-wire bus pins.
  input  wire logic              SCL_IN,
  output logic                   SCL_OUT,
  output logic                   SCL_OE,
  input  wire logic              SDA_IN,
  output logic                   SDA_OUT,
  output logic                   SDA_OE,
  // Straps and protection.
  input  wire logic [2:0]        DEV_SEL,
  input  wire logic              WRITE_PROTECT,
  // Flash program port.
  output logic                   FL_WR_VALID,
  input  wire logic              FL_WR_READY,
  output logic [ADDR_W-1:0]      FL_WR_ADDR,
  output logic [7:0]             FL_WR_DATA,
  // Flash erase port.
  output logic                   FL_ER_VALID,
  input  wire logic              FL_ER_READY,
  output logic                   FL_ER_FULL,
  output logic                   FL_ER_SECTOR,
  // Flash status and read port.
  input  wire logic              FL_BUSY,
  output logic [ADDR_W-1:0]      FL_RD_ADDR,
  input  wire logic [7:0]        FL_RD_DATA,
  // Internal cycle in progress.
  output logic                   CYCLE_BUSY
);
  localparam int PB = $clog2(PAGE);

  if (PAGE != 8 && PAGE != 16 && PAGE != 32) begin : g_bad_page
    $error("Page size must be 8, 16 or 32 bytes.");
  end
  if (ADDR_W < 7 || ADDR_W > 10) begin : g_bad_addr
    $error("Array address width must be 7 to 10 bits.");
  end
  if (READ_ONLY && ERASE != ifs_pkg::ER_NONE) begin : g_bad_erase
    $error("A read-only build must use the no-erase method.");
  end

  // ****************************************************************
  // Pin synchronisers and bus events.
  // ****************************************************************
  logic [5:0] meta_r;    // First stage, read only by the second.
  logic [5:0] sync_r;    // Second stage.
  logic [1:0] prev_r;    // Clock and data one cycle older.
  logic       scl_s;
  logic       sda_s;
  logic [2:0] sel_s;
  logic       wp_s;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_ev;
  logic       stop_ev;

  // All pins cross into the clock domain through two flip-flops.
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      meta_r <= 6'h3f;
      sync_r <= 6'h3f;
      prev_r <= 2'h3;
    end else begin
      meta_r <= {WRITE_PROTECT, DEV_SEL, SDA_IN, SCL_IN};
      sync_r <= meta_r;
      prev_r <= sync_r[1:0];
    end
  end

  assign scl_s    = sync_r[0];
  assign sda_s    = sync_r[1];
  assign sel_s    = sync_r[4:2];
  assign wp_s     = sync_r[5];
  assign scl_rise = scl_s && !prev_r[0];
  assign scl_fall = !scl_s && prev_r[0];
  assign start_ev = scl_s && prev_r[0] && prev_r[1] && !sda_s;
  assign stop_ev  = scl_s && prev_r[0] && !prev_r[1] && sda_s;

  // ****************************************************************
  // Byte decisions.
  // ****************************************************************
  ifs_pkg::ifs_link_t   st_r;     // Bit engine state.
  ifs_pkg::ifs_op_t     op_r;     // Operation of this transfer.
  ifs_pkg::ifs_commit_t cst_r;    // Commit engine state.
  logic [3:0]           bit_r;    // Bit count in the byte.
  logic [1:0]           byte_r;   // Byte index, saturating at two.
  logic [7:0]           shift_r;  // Received byte.
  logic [7:0]           tx_r;     // Byte being sent.
  logic                 drive_r;  // Pull data low.
  logic                 ack_r;    // Acknowledge given this byte.
  logic                 mack_r;   // Master acknowledged a read byte.
  logic                 armed_r;  // Erase may run at stop.
  logic [1:0]           hi_r;     // Select bits used as address.
  logic [ADDR_W-1:0]    addr_r;   // Array address pointer.
  logic [ADDR_W-1:0]    base_r;   // First address of the page.
  logic [PB:0]          cnt_r;    // Bytes held, saturating.
  logic [PB-1:0]        widx_r;   // Next buffer slot.
  logic [2:0]           mask;
  logic                 pfx_ok;
  logic                 exact;
  logic                 full_hit;
  logic [9:0]           full_addr;
  logic [ADDR_W-1:0]    rx_addr;
  logic                 busy;
  logic                 dec_ack;
  logic                 dec_arm;
  logic                 dec_store;
  ifs_pkg::ifs_op_t     dec_op;

  always_comb begin
    mask = 3'h7;
    if (ADDR_W >= 9) begin
      mask[0] = 1'b0;
    end
    if (ADDR_W >= 10) begin
      mask[1] = 1'b0;
    end
    // third bit is the erase flag
    if (ERASE == ifs_pkg::ER_SEL) begin
      mask[2] = 1'b0;
    end
  end

  assign pfx_ok    = (shift_r[7:`IFS_PFX_LSB] == PREFIX);
  assign exact     = pfx_ok && (((shift_r[3:`IFS_SEL_LSB] ^ sel_s) & mask) == 3'h0);
  assign full_hit  = (ERASE == ifs_pkg::ER_FULL) && pfx_ok && (shift_r[3:`IFS_SEL_LSB] == `IFS_SEL_FULL);
  assign full_addr = {hi_r, shift_r};
  assign rx_addr   = full_addr[ADDR_W-1:0];
  assign busy      = (cst_r != ifs_pkg::CS_IDLE);

  // Protection covers the upper half or the whole array.
  function automatic logic prot(input logic [ADDR_W-1:0] a);
    prot = READ_ONLY || (wp_s && (PROT_FULL || a[ADDR_W-1]));
  endfunction

  // Decide the answer to the byte that has just arrived.
  always_comb begin
    dec_ack   = 1'b0;
    dec_arm   = armed_r;
    dec_store = 1'b0;
    dec_op    = op_r;
    if (byte_r == 2'h0) begin
      dec_op = ifs_pkg::OP_NONE;
      if (exact && (ERASE == ifs_pkg::ER_SEL) && shift_r[3]) begin
        dec_op  = ifs_pkg::OP_SECT;
        dec_ack = 1'b1;
      end else if (exact) begin
        dec_op  = shift_r[`IFS_DIR_BIT] ? ifs_pkg::OP_READ : ifs_pkg::OP_WRITE;
        dec_ack = 1'b1;
      end else if (full_hit) begin
        dec_op  = ifs_pkg::OP_FULL;
        dec_ack = !(wp_s || READ_ONLY);
        dec_arm = dec_ack;
      end
    end else if (byte_r == 2'h1) begin
      dec_ack = 1'b1;
      if (op_r == ifs_pkg::OP_SECT) begin
        dec_ack = !prot(rx_addr);
        dec_arm = dec_ack;
      end
    end else if (op_r == ifs_pkg::OP_WRITE) begin
      dec_ack   = !prot(addr_r);
      dec_store = dec_ack;
      if (!dec_ack) begin
        dec_op = ifs_pkg::OP_NONE;
      end
    end else begin
      dec_ack = (op_r != ifs_pkg::OP_NONE);
    end
  end

  // ****************************************************************
  // Bit engine on the bus.
  // ****************************************************************
  // Shifts bytes in and out and drives the acknowledge slot.
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      st_r    <= ifs_pkg::LS_IDLE;
      op_r    <= ifs_pkg::OP_NONE;
      bit_r   <= 4'h0;
      byte_r  <= 2'h0;
      shift_r <= 8'h00;
      tx_r    <= 8'h00;
      drive_r <= 1'b0;
      ack_r   <= 1'b0;
      mack_r  <= 1'b0;
      armed_r <= 1'b0;
      hi_r    <= 2'h0;
      addr_r  <= '0;
      base_r  <= '0;
      cnt_r   <= '0;
      widx_r  <= '0;
    end else if (start_ev) begin
      // Start or repeated start opens a new address phase.
      drive_r <= 1'b0;
      bit_r   <= 4'h0;
      byte_r  <= 2'h0;
      op_r    <= ifs_pkg::OP_NONE;
      armed_r <= 1'b0;
      cnt_r   <= '0;
      widx_r  <= '0;
      st_r    <= busy ? ifs_pkg::LS_IDLE : ifs_pkg::LS_RX;
    end else if (stop_ev) begin
      // Stop hands the transfer to the commit engine.
      st_r    <= ifs_pkg::LS_IDLE;
      drive_r <= 1'b0;
      op_r    <= ifs_pkg::OP_NONE;
    end else begin
      case (st_r)
        ifs_pkg::LS_RX: begin
          if (scl_rise) begin
            shift_r <= {shift_r[6:0], sda_s};
            bit_r   <= bit_r + 4'h1;
          end else if (scl_fall && bit_r == `IFS_BYTE_BITS) begin
            bit_r   <= 4'h0;
            ack_r   <= dec_ack;
            drive_r <= dec_ack;
            op_r    <= dec_op;
            armed_r <= dec_arm;
            st_r    <= ifs_pkg::LS_ACK;
            if (byte_r != 2'h2) begin
              byte_r <= byte_r + 2'h1;
            end
            if (byte_r == 2'h0) begin
              hi_r <= shift_r[2:1];
            end
            if (byte_r == 2'h1) begin
              addr_r <= rx_addr;
              base_r <= rx_addr;
            end
            if (dec_store) begin
              widx_r <= widx_r + 1'b1;
              if (cnt_r != (PB+1)'(PAGE)) begin
                cnt_r <= cnt_r + 1'b1;
              end
            end
          end
        end
        ifs_pkg::LS_ACK: begin
          // hold low through the high phase
          if (scl_fall) begin
            if (!ack_r) begin
              drive_r <= 1'b0;
              st_r    <= ifs_pkg::LS_IDLE;
            end else if (op_r == ifs_pkg::OP_READ) begin
              tx_r    <= FL_RD_DATA;
              drive_r <= !FL_RD_DATA[7];
              st_r    <= ifs_pkg::LS_TX;
            end else begin
              drive_r <= 1'b0;
              st_r    <= ifs_pkg::LS_RX;
            end
          end
        end
        ifs_pkg::LS_TX: begin
          // Next data bit goes out on each falling clock.
          if (scl_fall) begin
            if (bit_r == 4'h7) begin
              bit_r   <= 4'h0;
              drive_r <= 1'b0;
              st_r    <= ifs_pkg::LS_RACK;
            end else begin
              bit_r   <= bit_r + 4'h1;
              tx_r    <= {tx_r[6:0], 1'b0};
              drive_r <= !tx_r[6];
            end
          end
        end
        ifs_pkg::LS_RACK: begin
          // Master answer; the pointer moves after every byte.
          if (scl_rise) begin
            mack_r <= !sda_s;
            addr_r <= addr_r + 1'b1;
          end else if (scl_fall) begin
            if (mack_r) begin
              tx_r    <= FL_RD_DATA;
              drive_r <= !FL_RD_DATA[7];
              st_r    <= ifs_pkg::LS_TX;
            end else begin
              st_r <= ifs_pkg::LS_IDLE;
            end
          end
        end
        default: begin
          st_r <= ifs_pkg::LS_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Page buffer.
  // ****************************************************************
  logic [7:0] page_r [PAGE];  // Data bytes waiting for stop.
  logic       buf_we;

  assign buf_we = (st_r == ifs_pkg::LS_RX) && scl_fall && (bit_r == `IFS_BYTE_BITS) && dec_store;

  for (genvar g = 0; g < PAGE; g++) begin : g_page
    always_ff @(posedge CLOCK) begin
      if (buf_we && widx_r == PB'(g)) begin
        page_r[g] <= shift_r;
      end
    end
  end

  // ****************************************************************
  // Commit engine towards the flash array.
  // ****************************************************************
  logic [PB-1:0]      ci_r;     // Buffer slot being queued.
  logic [PB:0]        ccnt_r;   // Bytes to queue.
  logic               fill_r;   // Programming still owed.
  logic               efull_r;  // Erase the whole array.
  logic               esec_r;   // Sector to erase.
  logic               hs_r;     // Program word taken last cycle.
  logic [PB-1:0]      low_sum;
  logic               trig_hit;
  logic               do_erase;
  ifs_pkg::ifs_word_t q_in;
  ifs_pkg::ifs_word_t q_out;
  logic               q_ready;
  logic               q_valid;

  assign low_sum  = base_r[PB-1:0] + ci_r;
  assign q_in     = '{addr: 10'({base_r[ADDR_W-1:PB], low_sum}), data: page_r[ci_r]};
  assign trig_hit = (base_r == TRIG0[ADDR_W-1:0]) || (base_r == TRIG1[ADDR_W-1:0]);
  // erase method decides what stop starts
  always_comb begin
    do_erase = 1'b0;
    case (op_r)
      ifs_pkg::OP_FULL: do_erase = armed_r;
      ifs_pkg::OP_SECT: do_erase = armed_r;
      ifs_pkg::OP_WRITE: do_erase = (ERASE == ifs_pkg::ER_BYTE) && (cnt_r != '0) && trig_hit;
      default: do_erase = 1'b0;
    endcase
  end

  // Starts erase and programming only once the stop is seen.
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      cst_r   <= ifs_pkg::CS_IDLE;
      ci_r    <= '0;
      ccnt_r  <= '0;
      fill_r  <= 1'b0;
      efull_r <= 1'b0;
      esec_r  <= 1'b0;
      hs_r    <= 1'b0;
    end else begin
      hs_r <= FL_WR_VALID && FL_WR_READY;
      case (cst_r)
        ifs_pkg::CS_IDLE: begin
          if (stop_ev) begin
            ci_r    <= '0;
            ccnt_r  <= cnt_r;
            fill_r  <= (op_r == ifs_pkg::OP_WRITE) && (cnt_r != '0);
            efull_r <= (op_r == ifs_pkg::OP_FULL);
            esec_r  <= base_r[ADDR_W-1];
            if (do_erase) begin
              cst_r <= ifs_pkg::CS_ERASE;
            end else if ((op_r == ifs_pkg::OP_WRITE) && (cnt_r != '0)) begin
              cst_r <= ifs_pkg::CS_FILL;
            end
          end
        end
        ifs_pkg::CS_ERASE: begin
          if (FL_ER_READY) begin
            cst_r <= ifs_pkg::CS_GAP;
          end
        end
        ifs_pkg::CS_FILL: begin
          // Queue one word per cycle; a full queue stalls here.
          if (q_ready) begin
            ci_r <= ci_r + 1'b1;
            if ((PB+1)'(ci_r) == ccnt_r - 1'b1) begin
              fill_r <= 1'b0;
              cst_r  <= ifs_pkg::CS_GAP;
            end
          end
        end
        ifs_pkg::CS_GAP: begin
          cst_r <= ifs_pkg::CS_WAIT;
        end
        ifs_pkg::CS_WAIT: begin
          // stay busy until the flash settles
          if (!q_valid && !FL_BUSY && !hs_r) begin
            cst_r <= fill_r ? ifs_pkg::CS_FILL : ifs_pkg::CS_IDLE;
          end
        end
        default: begin
          cst_r <= ifs_pkg::CS_IDLE;
        end
      endcase
    end
  end

  ifs_fifo #(
    .WIDTH ($bits(ifs_pkg::ifs_word_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_queue (
    .clk       (CLOCK),
    .rst       (RST),
    .in_valid  (cst_r == ifs_pkg::CS_FILL),
    .in_ready  (q_ready),
    .in_data   (q_in),
    .out_valid (q_valid),
    .out_ready (FL_WR_READY),
    .out_data  (q_out)
  );

  // ****************************************************************
  // Outputs.
  // ****************************************************************
  // The slave never stretches the clock; data is open drain.
  assign SCL_OUT      = 1'b0;
  assign SCL_OE       = 1'b0;
  assign SDA_OUT      = 1'b0;
  assign SDA_OE       = drive_r;
  assign FL_WR_VALID  = q_valid;
  assign FL_WR_ADDR   = q_out.addr[ADDR_W-1:0];
  assign FL_WR_DATA   = q_out.data;
  assign FL_ER_VALID  = (cst_r == ifs_pkg::CS_ERASE);
  assign FL_ER_FULL   = efull_r;
  assign FL_ER_SECTOR = esec_r;
  assign FL_RD_ADDR   = addr_r;
  assign CYCLE_BUSY   = busy;
endmodule : ifs_top
`default_nettype wire

/* File: ifs_master.sv */
`default_nettype none
// ****************************************************************
// Bus master model; a released wire reads high.
// ****************************************************************
module ifs_master (
  // Master drives.
  output logic     scl,
  output logic     sda,
  // Resolved data wire.
  input wire logic line
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] got;  // Last byte seen on the resolved wire.
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic start;
    sda = 1'b1;
    #40 scl = 1'b1;
    #40 sda = 1'b0;
    #40 scl = 1'b0;
  endtask
  task automatic bitx(input logic v, output logic s);
    #40 sda = v;
    #60 scl = 1'b1;
    #30 s = line;
    #30 scl = 1'b0;
  endtask
  task automatic send(input logic [7:0] b, output logic a);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitx(b[i], s);
      got[i] = s;
    end
    bitx(1'b1, s);
    a = ~s;
  endtask
  task automatic stop;
    #40 sda = 1'b0;
    #60 scl = 1'b1;
    #60 sda = 1'b1;
    #100;
  endtask
endmodule // ifs_master
`default_nettype wire

/* File: ifs_monitor.sv */
`default_nettype none
// ****************************************************************
// Port checker of the slave.
// ****************************************************************
module ifs_monitor #(
  parameter int ADDR_W = 8
) (
  // Clock, reset and bus.
  input wire logic              CLOCK,
  input wire logic              RST,
  input wire logic              SCL_IN,
  input wire logic              SDA_IN,
  input wire logic              SDA_OE,
  // Flash side.
  input wire logic              FL_WR_VALID,
  input wire logic              FL_WR_READY,
  input wire logic [ADDR_W-1:0] FL_WR_ADDR,
  input wire logic [7:0]        FL_WR_DATA,
  input wire logic              FL_ER_VALID,
  input wire logic              FL_BUSY,
  input wire logic              CYCLE_BUSY
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);
  // A program word held by a stalled flash.
  sequence s_stall;
    FL_WR_VALID && !FL_WR_READY;
  endsequence
  // Some flash request is up.
  sequence s_work;
    FL_WR_VALID || FL_ER_VALID;
  endsequence
  a_reset_quiet: assert property ($fell(RST) |-> !(SDA_OE || CYCLE_BUSY || FL_WR_VALID || FL_ER_VALID))
    else $error("busy after reset");
  a_ack_low_clk: assert property ($changed(SDA_OE) |-> !SCL_IN)
    else $error("drive moved in clock high");
  a_busy_no_ack: assert property (CYCLE_BUSY |-> !SDA_OE)
    else $error("ack while busy");
  a_stop_first: assert property ($rose(CYCLE_BUSY) |-> SCL_IN && SDA_IN)
    else $error("cycle before stop");
  a_work_soon: assert property ($rose(CYCLE_BUSY) |-> ##[0:2] s_work)
    else $error("no flash request");
  a_word_held: assert property (s_stall |=> FL_WR_VALID && $stable({FL_WR_ADDR, FL_WR_DATA}))
    else $error("word dropped");
  a_work_inside: assert property (FL_WR_VALID || FL_ER_VALID |-> CYCLE_BUSY)
    else $error("request outside cycle");
  a_busy_end: assert property ($fell(CYCLE_BUSY) |-> !$past(FL_BUSY) && !FL_WR_VALID && !FL_ER_VALID)
    else $error("cycle ended early");
endmodule // ifs_monitor
bind ifs_top ifs_monitor #(.ADDR_W(ADDR_W)) i_ifs_monitor (.CLOCK(CLOCK), .RST(RST), .SCL_IN(SCL_IN),
  .SDA_IN(SDA_IN), .SDA_OE(SDA_OE), .FL_WR_VALID(FL_WR_VALID), .FL_WR_READY(FL_WR_READY),
  .FL_WR_ADDR(FL_WR_ADDR), .FL_WR_DATA(FL_WR_DATA), .FL_ER_VALID(FL_ER_VALID), .FL_BUSY(FL_BUSY),
  .CYCLE_BUSY(CYCLE_BUSY));
`default_nettype wire

/* File: ifs_top_tb_top.sv */
`default_nettype none
module ifs_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLOCK = 1'b0, RST = 1'b1, WP = 1'b0, stall = 1'b0;
  logic scl, sda, sda_oe, wv, ev, efull, esec, cbusy, oe2, ev2, ef2, es2;
  logic [7:0] wa, wd, ack, ra;
  logic [15:0] words [$];
  logic [1:0] ers [$], ers2 [$];
  int bcnt = 0, n_errors = 0, checks = 0;
  // Rows: expected acks, address byte, second byte.
  logic [17:0] rows [6] = '{18'h3a405, 18'h1a5ff, 18'h0a605, 18'h02405, 18'h0ac05, 18'h0a005};
  wire rdy = bcnt == 0 && !stall;
  always #10 CLOCK = ~CLOCK;
  wire line = sda & !sda_oe & !oe2;
  ifs_master i_ifs_master (.scl(scl), .sda(sda), .line(line));
  ifs_top i_ifs_top (.CLOCK(CLOCK), .RST(RST), .SCL_IN(scl), .SCL_OUT(), .SCL_OE(), .SDA_IN(line),
    .SDA_OUT(), .SDA_OE(sda_oe), .DEV_SEL(3'h2), .WRITE_PROTECT(WP), .FL_WR_VALID(wv), .FL_WR_READY(rdy),
    .FL_WR_ADDR(wa), .FL_WR_DATA(wd), .FL_ER_VALID(ev), .FL_ER_READY(1'b1), .FL_ER_FULL(efull),
    .FL_ER_SECTOR(esec), .FL_BUSY(bcnt != 0), .FL_RD_ADDR(ra), .FL_RD_DATA(~ra), .CYCLE_BUSY(cbusy));
  // Second slave erases, on the third select bit, a sector named by the byte address.
  ifs_top #(.ERASE(ifs_pkg::ER_SEL)) i_ifs_top_sel (.CLOCK(CLOCK), .RST(RST), .SCL_IN(scl), .SCL_OUT(),
    .SCL_OE(), .SDA_IN(line), .SDA_OUT(), .SDA_OE(oe2), .DEV_SEL(3'h1), .WRITE_PROTECT(WP), .FL_WR_VALID(),
    .FL_WR_READY(1'b1), .FL_WR_ADDR(), .FL_WR_DATA(), .FL_ER_VALID(ev2), .FL_ER_READY(1'b1), .FL_ER_FULL(ef2),
    .FL_ER_SECTOR(es2), .FL_BUSY(1'b0), .FL_RD_ADDR(), .FL_RD_DATA(8'h00), .CYCLE_BUSY());
  // Flash model: each taken word or erase request of the first slave keeps it busy 150 cycles.
  // the model keeps no array; it only queues each taken word and erase request.
  always @(posedge CLOCK) begin
    if (wv && rdy) words.push_back({wa, wd});
    if (ev) ers.push_back({efull, esec});
    if (ev2) ers2.push_back({ef2, es2});
    if ((wv && rdy) || ev) bcnt <= 150;
    else if (bcnt > 0) bcnt <= bcnt - 1;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One framed transfer; ack bit i belongs to byte i.
  task automatic xfer(input logic [7:0] b [$]);
    @(posedge CLOCK) #1;
    ack = 8'h00;
    i_ifs_master.start();
    foreach (b[i]) i_ifs_master.send(b[i], ack[i]);
    i_ifs_master.stop();
  endtask
  task automatic idle;
    repeat (10) @(posedge CLOCK);
    for (int i = 0; i < 4000 && cbusy !== 1'b0; i++) @(posedge CLOCK);
    chk(16'(cbusy), 16'h0000);
  endtask
  task automatic end_sim;
    if (n_errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #1_000_000 n_errors++;
    end_sim();
  end
  initial begin
    repeat (2) @(posedge CLOCK);
    #1 RST = 1'b0;
    repeat (4) @(posedge CLOCK);
    foreach (rows[i]) begin
      xfer('{rows[i][15:8], rows[i][7:0]});
      chk(16'(ack), 16'(rows[i][17:16]));
    end
    xfer('{8'ha4, 8'h10, 8'h5a});
    chk(16'(ack), 16'h0007);
    xfer('{8'ha4});
    chk(16'(ack), 16'h0000);
    idle();
    xfer('{8'ha4});
    chk(16'(ack), 16'h0001);
    chk(words.pop_front(), 16'h105a);
    @(posedge CLOCK) #1 stall = 1'b1;
    xfer('{8'ha4, 8'h20, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06});
    chk(16'(ack), 16'h00ff);
    repeat (20) @(posedge CLOCK);
    #1 stall = 1'b0;
    chk(16'(words.size()), 16'h0000);
    idle();
    for (int i = 0; i < 6; i++) chk(words.pop_front(), {8'h20 + 8'(i), 8'h01 + 8'(i)});
    for (int s = 0; s < 2; s++) begin
      xfer('{8'ha4, 8'(s * 128), 8'h33});
      idle();
      chk(16'(ers.pop_front()), 16'(s));
      chk(words.pop_front(), {8'(s * 128), 8'h33});
    end
    xfer('{8'ha4, 8'h37});
    xfer('{8'ha5, 8'hff});
    chk({ack, i_ifs_master.got}, 16'h01c8);
    chk(16'(ra), 16'h0038);
    @(posedge CLOCK) #1 WP = 1'b1;
    xfer('{8'ha4, 8'h90, 8'h44});
    idle();
    chk(16'(ack), 16'h0003);
    chk(16'(words.size() + ers.size()), 16'h0000);
    xfer('{8'haa, 8'h90});
    chk(16'(ack), 16'h0001);
    xfer('{8'haa, 8'h10});
    idle();
    chk(16'(ack), 16'h0003);
    chk(16'(ers2.size()), 16'h0001);
    chk(16'(ers2.pop_front()), 16'h0000);
    @(posedge CLOCK) #1 RST = 1'b1;
    repeat (2) @(posedge CLOCK);
    #1 RST = 1'b0;
    @(posedge CLOCK) #1;
    chk(16'({ra, sda_oe, cbusy, wv, ev}), 16'h0000);
    end_sim();
  end
endmodule // ifs_top_tb_top
`default_nettype wire
